// ===== include/nv_defaults_pkg.sv
// Codes, byte layout and stored-settings type of the power-up defaults command
package nv_defaults_pkg;

  // Report framing
  localparam int REPORT_BYTES = 64;
  localparam logic [5:0] REPORT_LAST = 6'h3f;

  // Command and reply codes
  localparam logic [7:0] CMD_NV_WRITE = 8'h60;
  localparam logic [7:0] SUB_CHIP_DEFAULTS = 8'h20;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_BLOCKED = 8'hfb;
  localparam logic [7:0] STATUS_NOT_HANDLED = 8'hf9;

  // Byte positions in the command report
  localparam logic [5:0] BYTE_CODE = 6'h00;
  localparam logic [5:0] BYTE_SUB = 6'h01;
  localparam logic [5:0] BYTE_PIN0 = 6'h04;
  localparam logic [5:0] BYTE_PIN8 = 6'h0c;
  localparam logic [5:0] BYTE_LEVEL = 6'h0d;
  localparam logic [5:0] BYTE_DIR = 6'h0f;
  localparam logic [5:0] BYTE_FLAGS = 6'h11;
  localparam logic [5:0] BYTE_ACCESS = 6'h12;
  localparam logic [5:0] BYTE_PASS0 = 6'h13;

  // Reply byte positions
  localparam logic [5:0] REPLY_CODE = 6'h00;
  localparam logic [5:0] REPLY_STATUS = 6'h01;
  localparam logic [5:0] REPLY_SUB = 6'h02;

  // Fields of the flags byte
  localparam int FLAG_WAKE_BIT = 4;
  localparam int FLAG_MODE_LSB = 1;
  localparam int FLAG_KEEP_BIT = 0;

  // Pin designation codes
  localparam logic [1:0] DESIG_GPIO = 2'h0;
  localparam logic [1:0] DESIG_CHIP_SELECT = 2'h1;
  localparam logic [1:0] DESIG_DEDICATED = 2'h2;

  // Interrupt counting modes
  localparam logic [2:0] INT_NONE = 3'h0;
  localparam logic [2:0] INT_FALLING = 3'h1;
  localparam logic [2:0] INT_RISING = 3'h2;
  localparam logic [2:0] INT_LOW_PULSE = 3'h3;
  localparam logic [2:0] INT_HIGH_PULSE = 3'h4;

  // Access control codes
  localparam logic [7:0] ACCESS_OPEN = 8'h00;
  localparam logic [7:0] ACCESS_PASSWORD = 8'h40;
  localparam logic [7:0] ACCESS_LOCKED = 8'h80;

  typedef struct packed {
    logic [7:0][1:0] pin_desig;
    logic [1:0] pin8_desig;
    logic [7:0] out_level;
    logic [7:0] direction;
    logic wake_en;
    logic [2:0] int_mode;
    logic keep_bus;
    logic [7:0] access;
    logic [7:0][7:0] password;
  } settings_type;

  // Factory contents of the nonvolatile store
  localparam settings_type FACTORY_SETTINGS = '{
    pin_desig: {8{DESIG_GPIO}},
    pin8_desig: DESIG_GPIO,
    out_level: 8'h00,
    direction: 8'hff,
    wake_en: 1'b0,
    int_mode: INT_NONE,
    keep_bus: 1'b0,
    access: ACCESS_OPEN,
    password: 64'h0
  };

endpackage

// ===== logic/nv_settings_store.sv
// Nonvolatile power-up settings store, cleared to factory contents only by power-on
`timescale 1ns/10ps
module nv_settings_store
  import nv_defaults_pkg::*;
(
  // Clock and power-on reset
  input wire logic clock,
  input wire logic por,
  // Write port
  input wire logic write_en,
  input wire settings_type write_data,
  // Stored contents
  output settings_type stored
);

  typedef struct packed {
    settings_type cells;
  } store_state_type;

  store_state_type s_q;
  store_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (write_en) begin
      s_d.cells = write_data;
    end
  end

  // Pin reset does not reach here, so contents survive it
  always_ff @(posedge clock or posedge por) begin
    if (por) begin
      s_q <= '{cells: FACTORY_SETTINGS};
    end else begin
      s_q <= s_d;
    end
  end

  assign stored = s_q.cells;

endmodule

// ===== logic/power_up_defaults_command.sv
// Decoder and executor of the power-up chip settings write command
`timescale 1ns/10ps
module power_up_defaults_command
  import nv_defaults_pkg::*;
(
  // Clock and resets
  input wire logic clock,
  input wire logic rst,
  input wire logic por,
  // Command report bytes from the USB engine
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // Reply report bytes to the USB engine
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic rsp_ready,
  // Level from the password checker: correct password given
  input wire logic password_ok,
  // Working settings
  output logic [15:0] pin_designation,
  output logic [1:0] pin8_designation,
  output logic [7:0] default_level,
  output logic [7:0] default_direction,
  output logic remote_wakeup_en,
  output logic [2:0] int_count_mode,
  output logic spi_bus_keep,
  output logic [7:0] access_control,
  output logic [63:0] stored_password
);

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RECV = 2'b01,
    ST_REPLY = 2'b11
  } phase_type;

  typedef struct packed {
    phase_type phase;
    logic [5:0] idx;
    logic [7:0] code;
    logic [7:0] sub;
    settings_type staged;
    logic [7:0] status;
    logic nv_write;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    settings_type working;
  } state_type;

  state_type s_q;
  state_type s_d;
  settings_type nv_now;
  settings_type nv_write_data;

  // Reply content for one byte position
  function automatic logic [7:0] reply_byte(input logic [5:0] pos, input logic [7:0] code,
                                            input logic [7:0] status);
    logic [7:0] b;
    b = 8'h00;
    if (pos == REPLY_CODE) begin
      b = code;
    end else if (pos == REPLY_STATUS) begin
      b = status;
    end else if (pos == REPLY_SUB && status == STATUS_OK) begin
      b = SUB_CHIP_DEFAULTS;
    end
    return b;
  endfunction

  // Write is refused when locked, or password-protected without a valid password
  function automatic logic write_blocked(input logic [7:0] access, input logic pw_ok);
    logic blocked;
    blocked = 1'b0;
    if (access == ACCESS_LOCKED) begin
      blocked = 1'b1;
    end else if (access == ACCESS_PASSWORD && !pw_ok) begin
      blocked = 1'b1;
    end
    return blocked;
  endfunction

  always_comb begin
    logic [7:0] status_new;
    status_new = STATUS_OK;
    s_d = s_q;
    s_d.nv_write = 1'b0;
    case (s_q.phase)
      ST_LOAD: begin
        s_d.working = nv_now;
        s_d.phase = ST_RECV;
        s_d.cmd_ready = 1'b1;
        s_d.idx = 6'h00;
      end
      ST_RECV: begin
        if (cmd_valid) begin
          if (s_q.idx == BYTE_CODE) begin
            s_d.code = cmd_data;
            s_d.staged = nv_now;
          end
          if (s_q.idx == BYTE_SUB) begin
            s_d.sub = cmd_data;
          end
          for (int i = 0; i < 8; i++) begin
            if (s_q.idx == BYTE_PIN0 + 6'(i)) begin
              s_d.staged.pin_desig[i] = cmd_data[1:0];
            end
          end
          // pin 8 is input or dedicated only
          if (s_q.idx == BYTE_PIN8) begin
            s_d.staged.pin8_desig = (cmd_data[1:0] == DESIG_DEDICATED) ? DESIG_DEDICATED : DESIG_GPIO;
          end
          if (s_q.idx == BYTE_LEVEL) begin
            s_d.staged.out_level = cmd_data;
          end
          if (s_q.idx == BYTE_DIR) begin
            s_d.staged.direction = cmd_data;
          end
          if (s_q.idx == BYTE_FLAGS) begin
            s_d.staged.wake_en = cmd_data[FLAG_WAKE_BIT];
            // counting mode, reserved codes kept as sent
            s_d.staged.int_mode = cmd_data[FLAG_MODE_LSB +: 3];
            s_d.staged.keep_bus = cmd_data[FLAG_KEEP_BIT];
          end
          if (s_q.idx == BYTE_ACCESS) begin
            s_d.staged.access = cmd_data;
          end
          for (int i = 0; i < 8; i++) begin
            if (s_q.idx == BYTE_PASS0 + 6'(i)) begin
              s_d.staged.password[i] = cmd_data;
            end
          end
          s_d.idx = 6'(s_q.idx + 6'h01);
          if (s_q.idx == REPORT_LAST) begin
            if (s_q.code != CMD_NV_WRITE || s_q.sub != SUB_CHIP_DEFAULTS) begin
              status_new = STATUS_NOT_HANDLED;
            end else if (write_blocked(nv_now.access, password_ok)) begin
              status_new = STATUS_BLOCKED;
            end
            s_d.status = status_new;
            s_d.nv_write = (status_new == STATUS_OK);
            s_d.phase = ST_REPLY;
            s_d.cmd_ready = 1'b0;
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = reply_byte(REPLY_CODE, s_q.code, status_new);
            s_d.idx = 6'h00;
          end
        end
      end
      ST_REPLY: begin
        if (rsp_ready) begin
          if (s_q.idx == REPORT_LAST) begin
            s_d.rsp_valid = 1'b0;
            s_d.rsp_data = 8'h00;
            s_d.phase = ST_RECV;
            s_d.cmd_ready = 1'b1;
            s_d.idx = 6'h00;
          end else begin
            s_d.idx = 6'(s_q.idx + 6'h01);
            s_d.rsp_data = reply_byte(6'(s_q.idx + 6'h01), s_q.code, s_q.status);
          end
        end
      end
      default: begin
        s_d.phase = ST_LOAD;
      end
    endcase
  end

  // all-zero password means keep the stored one
  always_comb begin
    nv_write_data = s_q.staged;
    if (s_q.staged.password == '0) begin
      nv_write_data.password = nv_now.password;
    end
  end

  // Power-on also restarts the engine so the fresh store is loaded
  always_ff @(posedge clock or posedge rst or posedge por) begin
    if (rst || por) begin
      s_q <= '{phase: ST_LOAD, idx: 6'h00, code: 8'h00, sub: 8'h00, staged: FACTORY_SETTINGS,
               status: STATUS_OK, nv_write: 1'b0, cmd_ready: 1'b0, rsp_valid: 1'b0,
               rsp_data: 8'h00, working: FACTORY_SETTINGS};
    end else begin
      s_q <= s_d;
    end
  end

  nv_settings_store nv_store (
    .clock(clock),
    .por(por),
    .write_en(s_q.nv_write),
    .write_data(nv_write_data),
    .stored(nv_now)
  );

  // New defaults reach the outputs only after the next reset, working copy holds until then; the write check reads the stored access code
  assign cmd_ready = s_q.cmd_ready;
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_data = s_q.rsp_data;
  assign pin_designation = s_q.working.pin_desig;
  assign pin8_designation = s_q.working.pin8_desig;
  assign default_level = s_q.working.out_level;
  assign default_direction = s_q.working.direction;
  assign remote_wakeup_en = s_q.working.wake_en;
  assign int_count_mode = s_q.working.int_mode;
  assign spi_bus_keep = s_q.working.keep_bus;
  assign access_control = s_q.working.access;
  assign stored_password = s_q.working.password;

endmodule

// ===== verification/host_report_model.sv
// Behavioural host: sends one command report and drains its reply
`timescale 1ns/10ps
module host_report_model (
  // Clock
  input wire logic clock,
  // Command stream
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  input wire logic cmd_ready,
  // Reply stream
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  output logic rsp_ready
);
  initial begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    rsp_ready = 1'b0;
  end
  task automatic exchange(input logic [7:0] rep[64], output logic [7:0] rsp[64]);
    int k;
    logic take;
    k = 0;
    while (k < 64) begin
      @(negedge clock);
      cmd_valid = ($urandom % 4 != 0);
      // Idle data toggles so a stale byte is never mistaken for a fresh one
      cmd_data = cmd_valid ? rep[k] : ~cmd_data;
      // Ready is registered: mid-cycle value is what the next edge sees, no race
      take = cmd_valid && cmd_ready;
      @(posedge clock);
      if (take) k++;
    end
    k = 0;
    while (k < 64) begin
      @(negedge clock);
      cmd_valid = 1'b0;
      rsp_ready = ($urandom % 3 != 0);
      take = rsp_valid && rsp_ready;
      rsp[k] = rsp_data;
      @(posedge clock);
      if (take) k++;
    end
    @(negedge clock);
    rsp_ready = 1'b0;
  endtask
endmodule

// ===== verification/power_up_defaults_command_asserts.sv
// Port assertions for the power-up defaults command block
`timescale 1ns/10ps
module power_up_defaults_command_asserts
  import nv_defaults_pkg::*;
(
  // Clock and resets
  input wire logic clock,
  input wire logic rst,
  input wire logic por,
  // Streams
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_ready,
  // Working settings
  input wire logic [15:0] pin_designation,
  input wire logic [7:0] default_level,
  input wire logic [7:0] access_control,
  input wire logic [63:0] stored_password
);
  logic [5:0] n_q, r_q;
  logic [7:0] b0_q, b1_q, st_q;
  logic [1:0] ld_q;
  always_ff @(posedge clock or posedge rst or posedge por) begin
    if (rst || por) begin
      n_q <= 6'h00;
      r_q <= 6'h00;
      ld_q <= 2'h0;
    end else begin
      if (cmd_valid && cmd_ready) n_q <= n_q + 6'h01;
      if (cmd_valid && cmd_ready && n_q == 6'h00) b0_q <= cmd_data;
      if (cmd_valid && cmd_ready && n_q == 6'h01) b1_q <= cmd_data;
      if (rsp_valid && rsp_ready) r_q <= r_q + 6'h01;
      if (rsp_valid && r_q == 6'h01) st_q <= rsp_data;
      if (ld_q != 2'h2) ld_q <= ld_q + 2'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || por);
  AST_ONE_SIDE: assert property (!(cmd_ready && rsp_valid))
    else $error("command and reply open together");
  AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("reply byte not held");
  AST_LAST_BYTE: assert property (cmd_valid && cmd_ready && n_q == 6'h3f |=> rsp_valid && !cmd_ready)
    else $error("no reply after last byte");
  AST_ECHO: assert property ($rose(rsp_valid) |-> rsp_data == b0_q)
    else $error("code not echoed");
  AST_NOT_HANDLED: assert property ($rose(rsp_valid) && rsp_ready &&
    (b0_q != CMD_NV_WRITE || b1_q != SUB_CHIP_DEFAULTS) |=> rsp_data == STATUS_NOT_HANDLED)
    else $error("foreign command not refused");
  AST_LOCKED: assert property ($rose(rsp_valid) && rsp_ready && b1_q == SUB_CHIP_DEFAULTS &&
    b0_q == CMD_NV_WRITE && access_control == ACCESS_LOCKED |=> rsp_data == STATUS_BLOCKED)
    else $error("locked write not blocked");
  AST_SUB_ECHO: assert property (rsp_valid && r_q == 6'h02 |->
    rsp_data == (st_q == STATUS_OK ? SUB_CHIP_DEFAULTS : 8'h00)) else $error("bad third reply byte");
  AST_TAIL: assert property (rsp_valid && r_q > 6'h02 |-> rsp_data == 8'h00)
    else $error("reply tail not zero");
  AST_REPLY_END: assert property (rsp_valid && rsp_ready && r_q == 6'h3f |=> !rsp_valid && cmd_ready)
    else $error("reply not closed after 64 bytes");
  AST_LOAD: assert property (ld_q == 2'h1 |-> cmd_ready && !rsp_valid)
    else $error("not ready after load");
  AST_HELD: assert property (ld_q == 2'h2 |->
    $stable({pin_designation, default_level, access_control, stored_password})) else $error("settings moved");
  C_OK: cover property (rsp_valid && r_q == 6'h01 && rsp_data == STATUS_OK);
  C_BLOCKED: cover property (rsp_valid && r_q == 6'h01 && rsp_data == STATUS_BLOCKED);
  C_FOREIGN: cover property (rsp_valid && r_q == 6'h01 && rsp_data == STATUS_NOT_HANDLED);
endmodule
bind power_up_defaults_command power_up_defaults_command_asserts u_asserts (.clock(clock), .rst(rst), .por(por),
  .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_ready(rsp_ready), .pin_designation(pin_designation), .default_level(default_level),
  .access_control(access_control), .stored_password(stored_password));

// ===== verification/power_up_defaults_command_tb.sv
// Self-checking bench for the power-up defaults command block
`timescale 1ns/10ps
module power_up_defaults_command_tb
  import nv_defaults_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic password_ok = 1'b0;
  logic cmd_valid, cmd_ready, rsp_valid, rsp_ready, remote_wakeup_en, spi_bus_keep;
  logic [7:0] cmd_data, rsp_data, default_level, default_direction, access_control;
  logic [15:0] pin_designation;
  logic [1:0] pin8_designation;
  logic [2:0] int_count_mode;
  logic [63:0] stored_password;
  settings_type m;
  logic [7:0] rep[64];
  logic [7:0] rsp[64];
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 clock = ~clock;
  power_up_defaults_command u_dut (.clock(clock), .rst(rst), .por(por), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ready(rsp_ready), .password_ok(password_ok), .pin_designation(pin_designation),
    .pin8_designation(pin8_designation), .default_level(default_level), .default_direction(default_direction),
    .remote_wakeup_en(remote_wakeup_en), .int_count_mode(int_count_mode), .spi_bus_keep(spi_bus_keep),
    .access_control(access_control), .stored_password(stored_password));
  host_report_model u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready));
  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_set(input settings_type got, input settings_type exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pin reset keeps the store; power-on returns it to factory contents
  task automatic do_reset(input logic power);
    @(negedge clock);
    rst = 1'b1;
    por = power;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    por = 1'b0;
    if (power) m = FACTORY_SETTINGS;
    repeat (2) @(negedge clock);
    chk_set({pin_designation, pin8_designation, default_level, default_direction, remote_wakeup_en,
      int_count_mode, spi_bus_keep, access_control, stored_password}, m);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    logic ok;
    logic [7:0] st;
    logic [63:0] pw;
    void'($urandom(2521));
    do_reset(1'b1);
    for (int i = 0; i < 16; i++) begin
      foreach (rep[j]) rep[j] = 8'h00;
      rep[0] = CMD_NV_WRITE;
      rep[1] = (i % 5 == 4) ? 8'h10 : SUB_CHIP_DEFAULTS;
      for (int j = 4; j < 17; j++) rep[j] = (j < 12) ? 8'($urandom % 3) : 8'($urandom);
      rep[12] = {6'h00, 1'($urandom), 1'b0};
      rep[17] = {3'($urandom), 1'($urandom), 3'(i), 1'($urandom)};
      // Open at first, then password protected, then locked for good
      rep[18] = (i == 12) ? ACCESS_LOCKED : (i > 5) ? ACCESS_PASSWORD : ACCESS_OPEN;
      for (int j = 19; j < 27; j++) rep[j] = (i % 3 == 0) ? 8'h00 : 8'($urandom);
      password_ok = (i == 12) || 1'($urandom);
      ok = m.access != ACCESS_LOCKED && (m.access != ACCESS_PASSWORD || password_ok);
      st = (rep[1] != SUB_CHIP_DEFAULTS) ? STATUS_NOT_HANDLED : ok ? STATUS_OK : STATUS_BLOCKED;
      u_host.exchange(rep, rsp);
      chk_byte(rsp[0], rep[0]);
      chk_byte(rsp[1], st);
      chk_byte(rsp[2], (st == STATUS_OK) ? SUB_CHIP_DEFAULTS : 8'h00);
      for (int j = 3; j < 64; j++) chk_byte(rsp[j], 8'h00);
      if (st == STATUS_OK) begin
        for (int j = 0; j < 8; j++) m.pin_desig[j] = rep[4 + j][1:0];
        m.pin8_desig = (rep[12] == 8'h02) ? DESIG_DEDICATED : DESIG_GPIO;
        m.out_level = rep[13];
        m.direction = rep[15];
        {m.wake_en, m.int_mode, m.keep_bus} = rep[17][4:0];
        m.access = rep[18];
        for (int j = 0; j < 8; j++) pw[8 * j +: 8] = rep[19 + j];
        if (pw != 64'h0) m.password = pw;
      end
      do_reset(1'b0);
    end
    do_reset(1'b1);
    summarize();
  end
endmodule
